// File: rtl/mtmr_top.sv
// 8-bit modulo timer with prescaler and axi4-lite register slave
`timescale 1ns/1ps
import mtmr_pkg::*;
module mtmr_top
(
    input  wire logic        clk,             // bus clock, 200 MHz
    input  wire logic        arst_n,          // async reset, active low
    input  wire logic        fixed_rate_clock, // fixed-rate source pin
    input  wire logic        ext_count_pin,   // external count pin
    output logic             overflow_irq,    // interrupt request, high
    input  wire logic [31:0] s_axi_awaddr,    // write address
    input  wire logic        s_axi_awvalid,   // write address valid
    output logic             s_axi_awready,   // write address ready
    input  wire logic [31:0] s_axi_wdata,     // write data
    input  wire logic [3:0]  s_axi_wstrb,     // write strobes
    input  wire logic        s_axi_wvalid,    // write data valid
    output logic             s_axi_wready,    // write data ready
    output logic [1:0]       s_axi_bresp,     // write response
    output logic             s_axi_bvalid,    // write response valid
    input  wire logic        s_axi_bready,    // write response ready
    input  wire logic [31:0] s_axi_araddr,    // read address
    input  wire logic        s_axi_arvalid,   // read address valid
    output logic             s_axi_arready,   // read address ready
    output logic [31:0]      s_axi_rdata,     // read data
    output logic [1:0]       s_axi_rresp,     // read response
    output logic             s_axi_rvalid,    // read data valid
    input  wire logic        s_axi_rready     // read data ready
);
    import mtmr_pkg::*;

    mtmr_ctrl_t ctrl;
    mtmr_wev_t  wev;
    logic [7:0] timer_count_value;
    logic [7:0] timer_modulo_value;
    logic       overflow_flag;
    logic       clear_armed;
    logic       aw_held;
    logic       w_held;
    logic [MTMR_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        rd_take;
    logic [MTMR_ADDR_W-1:0] rd_addr;
    logic [31:0] next_rdata;
    logic        rd_ok;
    logic        wr_ok;
    logic        fix_rise;
    logic        fix_fall;
    logic        pin_rise;
    logic        pin_fall;
    logic        src_en;
    logic        tick;
    logic        wrap;
    logic        overflow_event;

    // ---- write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[MTMR_ADDR_W-1:0];
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    assign wr_ok = (aw_addr[MTMR_ADDR_LSB-1:0] == '0);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= MTMR_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? MTMR_RESP_OKAY : MTMR_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // only byte lane 0 carries register bits
    always_comb
    begin
        wev = '0;
        if (do_write && wr_ok && w_strb[0])
        begin
            unique case (aw_addr)
                MTMR_OFS_STATUS_CONTROL:
                begin
                    wev.status_wr    = 1'b1;
                    wev.clear_strobe = w_data[MTMR_BIT_CLR];
                    wev.flag_wr0     = !w_data[MTMR_BIT_OVF];
                end
                MTMR_OFS_MODULO_VALUE:
                    wev.modulo_wr = 1'b1;
                default:
                    wev.status_wr = 1'b0;
            endcase
        end
        wev.modulo_data = w_data[7:0];
        wev.status_rd   = rd_take && (rd_addr == MTMR_OFS_STATUS_CONTROL);
    end

    // ---- read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take       = s_axi_arvalid && s_axi_arready;
    assign rd_addr       = s_axi_araddr[MTMR_ADDR_W-1:0];
    assign rd_ok         = (rd_addr[MTMR_ADDR_LSB-1:0] == '0);

    always_comb
    begin
        next_rdata = '0;
        unique case (rd_addr)
            MTMR_OFS_STATUS_CONTROL:
            begin
                next_rdata[MTMR_BIT_OVF]   = overflow_flag;
                next_rdata[MTMR_BIT_IRQEN] = ctrl.irq_enable;
                next_rdata[MTMR_BIT_HALT]  = ctrl.halt;  // clear bit reads 0
            end
            MTMR_OFS_CLOCK_CONFIG:
            begin
                next_rdata[MTMR_SRC_MSB:MTMR_SRC_LSB] = ctrl.source;
                next_rdata[MTMR_PS_MSB:0]             = ctrl.prescale;
            end
            MTMR_OFS_COUNT_VALUE:
                next_rdata[7:0] = timer_count_value;
            MTMR_OFS_MODULO_VALUE:
                next_rdata[7:0] = timer_modulo_value;
            default:
                next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= MTMR_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? next_rdata : '0;
            s_axi_rresp  <= rd_ok ? MTMR_RESP_OKAY : MTMR_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ---- control registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl.halt       <= 1'b1;
            ctrl.irq_enable <= 1'b0;
            ctrl.source     <= MTMR_SRC_BUS;
            ctrl.prescale   <= MTMR_PS_RST;
        end
        else if (do_write && wr_ok && w_strb[0])
        begin
            if (aw_addr == MTMR_OFS_STATUS_CONTROL)
            begin
                ctrl.halt       <= w_data[MTMR_BIT_HALT];
                ctrl.irq_enable <= w_data[MTMR_BIT_IRQEN];
            end
            else if (aw_addr == MTMR_OFS_CLOCK_CONFIG)
            begin
                ctrl.source   <= mtmr_src_t'(w_data[MTMR_SRC_MSB:MTMR_SRC_LSB]);
                ctrl.prescale <= w_data[MTMR_PS_MSB:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timer_modulo_value <= MTMR_MODULO_RST;
        else if (wev.modulo_wr)
            timer_modulo_value <= wev.modulo_data;
    end

    // ---- counting sources, both pins synchronised
    mtmr_sync_edge u_fixed_sync
    (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (fixed_rate_clock),
        .rise   (fix_rise),
        .fall   ()
    );

    mtmr_sync_edge u_pin_sync
    (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (ext_count_pin),
        .rise   (pin_rise),                                               
        .fall   (pin_fall)
    );
    assign fix_fall = 1'b0;

    // selection is purely combinational so a change keeps the count
    always_comb
    begin
        unique case (ctrl.source)
            MTMR_SRC_BUS:   src_en = 1'b1;
            MTMR_SRC_FIXED: src_en = fix_rise | fix_fall;
            MTMR_SRC_FALL:  src_en = pin_fall;
            MTMR_SRC_RISE:  src_en = pin_rise;
        endcase
    end

    mtmr_prescaler #(.DIV_W(8)) u_prescaler
    (
        .clk    (clk),
        .arst_n (arst_n),
        .src_en (src_en),
        .run    (!ctrl.halt),
        .select (ctrl.prescale),
        .tick   (tick)
    );

    // ---- counter: modulo zero lets the 8-bit count roll over at ff
    assign wrap = (timer_modulo_value == MTMR_MODULO_RST)
                ? (timer_count_value == 8'hff)
                : (timer_count_value == timer_modulo_value);
    assign overflow_event = tick && wrap;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timer_count_value <= MTMR_COUNT_RST;
        else if (wev.clear_strobe || (wev.modulo_wr && !ctrl.halt))
            timer_count_value <= MTMR_COUNT_RST;
        else if (tick)
            timer_count_value <= wrap ? MTMR_COUNT_RST
                                      : timer_count_value + 8'h01;
    end

    // ---- overflow flag with two-step clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            clear_armed <= 1'b0;
        else if (overflow_event || wev.status_wr)
            clear_armed <= 1'b0;
        else if (wev.status_rd && overflow_flag)
            clear_armed <= 1'b1;
    end

    // a new overflow always wins over any clearing action
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overflow_flag <= 1'b0;
        else if (overflow_event)
            overflow_flag <= 1'b1;
        else if (wev.clear_strobe || wev.modulo_wr)
            overflow_flag <= 1'b0;
        else if (wev.status_wr && wev.flag_wr0 && clear_armed)
            overflow_flag <= 1'b0;
    end

    assign overflow_irq = overflow_flag & ctrl.irq_enable;

    a_flag_sets: assert property (@(posedge clk) disable iff (!arst_n)
        overflow_event |=> overflow_flag && timer_count_value == 8'h00)
        else $error("overflow did not set flag and zero count");
    a_halt_freezes: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl.halt && !wev.clear_strobe && !wev.modulo_wr
        |=> $stable(timer_count_value))
        else $error("count moved while halted");
    a_irq_follows: assert property (@(posedge clk) disable iff (!arst_n)
        overflow_irq == (overflow_flag && ctrl.irq_enable))
        else $error("irq mismatch");
    a_strobe_clears: assert property (@(posedge clk) disable iff (!arst_n)
        wev.clear_strobe && !overflow_event
        |=> timer_count_value == 8'h00 && !overflow_flag)
        else $error("clear strobe failed");
    a_no_blind_clear: assert property (@(posedge clk) disable iff (!arst_n)
        overflow_flag && !clear_armed && !wev.clear_strobe && !wev.modulo_wr
        |=> overflow_flag)
        else $error("flag cleared without read");
    a_mod_wr_clears: assert property (@(posedge clk) disable iff (!arst_n)
        wev.modulo_wr && !ctrl.halt && !wev.clear_strobe && !overflow_event
        |=> timer_count_value == 8'h00 && !overflow_flag)
        else $error("modulo write did not clear");
    a_mod_bound: assert property (@(posedge clk) disable iff (!arst_n)
        timer_modulo_value != 8'h00 && $past(timer_count_value)
        == timer_modulo_value && $past(tick) && !$past(wev.clear_strobe)
        && !$past(wev.modulo_wr) |-> timer_count_value == 8'h00)
        else $error("no wrap at modulo");
    a_tick_steps: assert property (@(posedge clk) disable iff (!arst_n)
        tick && !wrap && !wev.clear_strobe && !wev.modulo_wr
        |=> timer_count_value == $past(timer_count_value) + 8'h01)
        else $error("count did not step");

    c_overflow: cover property (@(posedge clk) disable iff (!arst_n)
        overflow_event);
    c_two_step: cover property (@(posedge clk) disable iff (!arst_n)
        clear_armed ##[1:20] !overflow_flag);
    c_cancel: cover property (@(posedge clk) disable iff (!arst_n)
        clear_armed && overflow_event);
endmodule

// File: rtl/mtmr_pkg.sv
// package: register map, field layout and reset values of the modulo timer
package mtmr_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [3:0] MTMR_OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] MTMR_OFS_CLOCK_CONFIG   = 4'h4;
    localparam logic [3:0] MTMR_OFS_COUNT_VALUE    = 4'h8;
    localparam logic [3:0] MTMR_OFS_MODULO_VALUE   = 4'hc;
    localparam int MTMR_ADDR_W = 4;
    localparam int MTMR_ADDR_LSB = 2;

    // timer_status_control bit positions
    localparam int MTMR_BIT_OVF   = 7;
    localparam int MTMR_BIT_IRQEN = 6;
    localparam int MTMR_BIT_CLR   = 5;
    localparam int MTMR_BIT_HALT  = 4;
    // timer_clock_config field positions
    localparam int MTMR_SRC_LSB = 4;
    localparam int MTMR_SRC_MSB = 5;
    localparam int MTMR_PS_MSB  = 3;

    localparam logic [7:0] MTMR_COUNT_RST  = 8'h00;
    localparam logic [7:0] MTMR_MODULO_RST = 8'h00;
    localparam logic [3:0] MTMR_PS_RST     = 4'h0;
    localparam logic [3:0] MTMR_PS_MAX     = 4'h8;

    localparam logic [1:0] MTMR_RESP_OKAY   = 2'b00;
    localparam logic [1:0] MTMR_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0]
    {
        MTMR_SRC_BUS  = 2'b00,
        MTMR_SRC_FIXED = 2'b01,
        MTMR_SRC_FALL = 2'b10,
        MTMR_SRC_RISE = 2'b11
    } mtmr_src_t;

    // software-visible control fields
    typedef struct packed
    {
        logic      halt;
        logic      irq_enable;
        mtmr_src_t source;
        logic [3:0] prescale;
    } mtmr_ctrl_t;

    // one-cycle write and status-read side effects from the bus slave
    typedef struct packed
    {
        logic       status_wr;
        logic       status_rd;
        logic       clear_strobe;
        logic       flag_wr0;
        logic       modulo_wr;
        logic [7:0] modulo_data;
    } mtmr_wev_t;
endpackage

// File: rtl/mtmr_sync_edge.sv
// synchroniser and edge detector for the fixed-rate and external count pins
`timescale 1ns/1ps
module mtmr_sync_edge
(
    input  wire logic clk,     // bus clock
    input  wire logic arst_n,  // async reset, active low
    input  wire logic pin,     // raw fixed_rate_clock or ext_count_pin
    output logic      rise,    // one-cycle pulse on rising edge
    output logic      fall     // one-cycle pulse on falling edge
);
    logic meta;
    logic sync;
    logic prev;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

// File: rtl/mtmr_prescaler.sv
// power-of-two prescaler giving a one-cycle tick per divided source event
`timescale 1ns/1ps
module mtmr_prescaler
#(
    parameter int DIV_W = 8    // prescaler stages, divide up to 2**DIV_W
)
(
    input  wire logic       clk,      // bus clock
    input  wire logic       arst_n,   // async reset, active low
    input  wire logic       src_en,   // one source event this cycle
    input  wire logic       run,      // counter not halted
    input  wire logic [3:0] select,   // prescale_select code
    output logic            tick      // one-cycle divided tick
);
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] mask;
    logic [3:0]       sel_eff;

    // unused codes above the top ratio act as the top ratio
    assign sel_eff = (select > 4'(DIV_W)) ? 4'(DIV_W) : select;
    assign mask    = DIV_W'((9'h001 << sel_eff) - 9'h001);
    assign tick    = run & src_en & ((div & mask) == mask);

    // the divider keeps running across ratio changes so the count is kept
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            div <= '0;
        else if (run && src_en)
            div <= div + DIV_W'(1);
    end
endmodule

// File: tb/mtmr_tb.sv
// self-checking bench for the modulo timer over its axi4-lite slave
`timescale 1ns/1ps
module testbench;
    import mtmr_pkg::*;
    localparam logic [31:0] SC = 32'(MTMR_OFS_STATUS_CONTROL);
    localparam logic [31:0] CK = 32'(MTMR_OFS_CLOCK_CONFIG);
    localparam logic [31:0] CN = 32'(MTMR_OFS_COUNT_VALUE);
    localparam logic [31:0] MD = 32'(MTMR_OFS_MODULO_VALUE);
    logic        clk;
    logic        arst_n;
    logic        fixed_rate_clock;
    logic        ext_count_pin;
    logic        overflow_irq;
    logic [31:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    int          mismatches = 0;
    int          checked = 0;
    int          cyc = 0;

    mtmr_top dut_u
    (
        .clk(clk), .arst_n(arst_n), .fixed_rate_clock(fixed_rate_clock),
        .ext_count_pin(ext_count_pin), .overflow_irq(overflow_irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // range check: prescaler phase is not visible from the bus
    task automatic chk_rng(input logic [31:0] got, input int lo, hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'h1)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h..%h",
                     $time, got, lo, hi);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw && w))
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready === 1'h1)
            begin
                aw = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'h1)
            begin
                w = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (s_axi_bvalid !== 1'h1)
            @(posedge clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(32'(r), 32'(MTMR_RESP_OKAY));
    endtask

    task automatic rc(input logic [31:0] a, exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(32'(r), 32'(MTMR_RESP_OKAY));
        chk(d, exp);
    endtask

    task automatic pulse(input bit pin, input int n);
        repeat (n)
        begin
            if (pin)
                ext_count_pin <= 1'h1;
            else
                fixed_rate_clock <= 1'h1;
            repeat (4) @(posedge clk);
            if (pin)
                ext_count_pin <= 1'h0;
            else
                fixed_rate_clock <= 1'h0;
            repeat (6) @(posedge clk);
        end
    endtask

    initial
    begin
        #300000;
        mismatches++;
        close_out();
    end

    initial
    begin
        static int   codes[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15};
        int          tr, tp, th, prev, dold, dnew, e;
        logic [31:0] d;
        logic [1:0]  r;
        clk = 1'h0;
        arst_n = 1'h0;
        fixed_rate_clock = 1'h0;
        ext_count_pin = 1'h0;
        s_axi_awaddr = 32'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_araddr = 32'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;

        rc(SC, 32'h10);
        rc(CK, 32'h0);
        rc(CN, 32'h0);
        rc(MD, 32'h0);
        chk({31'h0, overflow_irq}, 32'h0);
        axi_wr(32'h1, 32'h0, r);
        chk(32'(r), 32'(MTMR_RESP_SLVERR));
        axi_rd(32'h2, d, r);
        chk(32'(r), 32'(MTMR_RESP_SLVERR));
        wr(CN, 32'hff);
        rc(CN, 32'h0);
        wr(CK, 32'h3f);
        rc(CK, 32'h3f);
        wr(CK, 32'h0);
        wr(SC, 32'h30);
        rc(SC, 32'h10);
        $display("test registers finished");

        // ratio changed while running; count accumulates across steps
        prev = 0;
        dold = 1;
        foreach (codes[i])
        begin
            dnew = 1 << ((codes[i] > 8) ? 8 : codes[i]);
            wr(SC, 32'h0);
            tr = cyc;
            wr(CK, 32'(codes[i]));
            tp = cyc;
            repeat (16 * dnew) @(posedge clk);
            wr(SC, 32'h10);
            th = cyc;
            axi_rd(CN, d, r);
            e = prev + (tp - tr) / dold + (th - tp) / dnew;
            chk_rng(d, e - 2, e + 2);
            prev = int'(d);
            dold = dnew;
        end
        rc(SC, 32'h10);
        $display("test prescaler finished");

        wr(CK, 32'h0);
        wr(SC, 32'h0);
        repeat (150) @(posedge clk);
        wr(SC, 32'h10);
        rc(SC, 32'h90);
        axi_rd(CN, d, r);
        repeat (20) @(posedge clk);
        rc(CN, d);
        wr(SC, 32'h30);
        rc(SC, 32'h10);
        rc(CN, 32'h0);
        $display("test free run finished");

        wr(CK, 32'h10);
        wr(SC, 32'h0);
        pulse(0, 3);
        wr(CK, 32'h30);
        pulse(1, 3);
        wr(SC, 32'h10);
        rc(CN, 32'h6);
        wr(CK, 32'h20);
        wr(SC, 32'h0);
        pulse(1, 2);
        wr(SC, 32'h10);
        rc(CN, 32'h8);
        $display("test sources finished");

        wr(SC, 32'h30);
        wr(MD, 32'h2);
        wr(CK, 32'h30);
        wr(SC, 32'h0);
        pulse(1, 2);
        rc(CN, 32'h2);
        rc(SC, 32'h0);
        pulse(1, 1);
        rc(CN, 32'h0);
        rc(SC, 32'h80);
        wr(SC, 32'h0);
        rc(SC, 32'h0);
        pulse(1, 3);
        rc(SC, 32'h80);
        pulse(1, 3);
        wr(SC, 32'h0);
        rc(SC, 32'h80);
        wr(SC, 32'h80);
        wr(SC, 32'h0);
        rc(SC, 32'h80);
        chk({31'h0, overflow_irq}, 32'h0);
        wr(SC, 32'h30);
        rc(SC, 32'h10);
        wr(SC, 32'h40);
        pulse(1, 3);
        chk({31'h0, overflow_irq}, 32'h1);
        rc(SC, 32'hc0);
        pulse(1, 1);
        wr(MD, 32'h3);
        rc(CN, 32'h0);
        rc(SC, 32'h40);
        chk({31'h0, overflow_irq}, 32'h0);
        $display("test overflow flag finished");
        close_out();
    end
endmodule
